// >>> verilog/ssd_defs.vh
// Constants for the safe slave data path: register map, fields, resets
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SSD_ADDR_W          12
`define SSD_OFS_CONFIG      12'h000
`define SSD_OFS_STATUS      12'h004
`define SSD_OFS_DATA        12'h008

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define SSD_CFG_W           15
`define SSD_CFG_SAFETY      0
`define SSD_CFG_EXT_ADDR    1
`define SSD_CFG_BANKED      2
`define SSD_CFG_SYNC_IO     3
`define SSD_CFG_JOINT_INV   4
`define SSD_CFG_B_SLAVE     5
`define SSD_CFG_INV_LO      6
`define SSD_CFG_INV_HI      9
`define SSD_CFG_FILT_LO     10
`define SSD_CFG_FILT_HI     13
`define SSD_CFG_RESET       15'h0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SSD_ST_BLOCK        0
`define SSD_ST_SAFETY       1
`define SSD_ST_PREV_I2      2
`define SSD_ST_LOCK         3
`define SSD_ST_HOLD_LO      4
`define SSD_ST_HOLD_HI      5
`define SSD_ST_FIFO_LO      8
`define SSD_ST_FIFO_HI      11

// ----------------------------------------------------------------
// Data register fields
// ----------------------------------------------------------------
`define SSD_DAT_IN_LO       0
`define SSD_DAT_IN_HI       3
`define SSD_DAT_OUT_LO      4
`define SSD_DAT_OUT_HI      7

// ----------------------------------------------------------------
// Call word: info bits plus kind bit
// ----------------------------------------------------------------
`define SSD_CALL_W          5
`define SSD_CALL_KIND       4
`define SSD_KIND_EXCHANGE   1'h0
`define SSD_KIND_PARAM      1'h1
`define SSD_FIFO_DEPTH      8
`define SSD_FIFO_AW         3

// ----------------------------------------------------------------
// Bit positions of call bits I0..I3 and data bits D0..D3
// ----------------------------------------------------------------
`define SSD_I0              0
`define SSD_I1              1
`define SSD_I2              2
`define SSD_I3              3
`define SSD_D0              0
`define SSD_D1              1
`define SSD_D2              2
`define SSD_D3              3

`endif

// >>> verilog/ssd_fifo.v
// Flip-flop FIFO with valid/ready on both sides and a clock enable
module ssd_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    input  wire             clk_en,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Fill level
    output wire [AW:0]      level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire push = clk_en & in_valid & in_ready;
    wire pop  = clk_en & out_valid & out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign level     = count;

    always @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

// >>> verilog/ssd_data_path.v
// Slave data-port path: banked outputs, safety input path, APB registers
//
// Added by the designer: the address map and the APB register port.
`include "ssd_defs.vh"

module ssd_data_path (
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Decoded master calls
    input  wire        call_valid,
    output wire        call_ready_q,
    input  wire        call_param,
    input  wire [3:0]  call_info,
    // Slave answer to the master
    output reg         resp_valid,
    input  wire        resp_ready,
    output reg  [3:0]  resp_data,
    // Data port pins
    input  wire [3:0]  data_in_pin,
    output reg  [3:0]  data_out,
    output reg         data_strobe
);

    // ----------------------------------------------------------------
    // Configuration and state
    // ----------------------------------------------------------------
    reg  [`SSD_CFG_W-1:0] config_reg;
    reg                   exchange_block;
    reg                   prev_i2;
    reg                   pair_one_low_hold;
    reg                   pair_one_high_hold;
    reg                   call_ready_r;

    wire safety_flag        = config_reg[`SSD_CFG_SAFETY];
    wire ext_addr_mode      = config_reg[`SSD_CFG_EXT_ADDR];
    wire banked_output_mode = config_reg[`SSD_CFG_BANKED];
    wire sync_io            = config_reg[`SSD_CFG_SYNC_IO];
    wire joint_invert       = config_reg[`SSD_CFG_JOINT_INV];
    wire b_slave            = config_reg[`SSD_CFG_B_SLAVE];
    wire [3:0] input_invert_bit_select =
        config_reg[`SSD_CFG_INV_HI:`SSD_CFG_INV_LO];
    wire [3:0] input_filter_settings =
        config_reg[`SSD_CFG_FILT_HI:`SSD_CFG_FILT_LO];

    wire safety_on = safety_flag;
    wire safety_n  = ~safety_on;

    wire safety_lock = safety_on & (sync_io | (|input_filter_settings));

    wire banked = ext_addr_mode & banked_output_mode;

    // ----------------------------------------------------------------
    // Input pin synchroniser
    // ----------------------------------------------------------------
    // Three stages; a change is taken only once stages two and three agree
    reg [3:0] din_s1;
    reg [3:0] din_s2;
    reg [3:0] din_s3;
    reg [3:0] din_stable;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_s1     <= 4'h0;
            din_s2     <= 4'h0;
            din_s3     <= 4'h0;
            din_stable <= 4'h0;
        end else if (clk_en) begin
            din_s1 <= data_in_pin;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            if (din_s2 == din_s3) begin
                din_stable <= din_s3;
            end
        end
    end

    // ----------------------------------------------------------------
    // Input processing paths
    // ----------------------------------------------------------------
    // inverters first
    wire [3:0] phys_inv = din_stable ^ {4{joint_invert}}
                          ^ input_invert_bit_select;

    // Inverted bits by physical pin
    wire pin_d0 = phys_inv[`SSD_D0];
    wire pin_d1 = phys_inv[`SSD_D1];
    wire pin_d2 = phys_inv[`SSD_D2];
    wire pin_d3 = phys_inv[`SSD_D3];

    wire logical_input_two   = pin_d3;
    wire logical_input_three = pin_d2;

    wire safe_d0 = pin_d0 ^ (pin_d1 & logical_input_two
                             & logical_input_three);
    wire [3:0] safety_path = {logical_input_three, logical_input_two,
                              pin_d1, safe_d0};

    wire [3:0] regular_path = (phys_inv & {4{safety_n}})
                              | {4{safety_on}};

    wire [3:0] send_data = safety_on ? safety_path : regular_path;

    // ----------------------------------------------------------------
    // Call FIFO
    // ----------------------------------------------------------------
    wire [`SSD_CALL_W-1:0]  fifo_out;
    wire                    fifo_out_valid;
    wire                    fifo_in_ready;
    wire [`SSD_FIFO_AW:0]   fifo_level;

    // The answer port can stall, so calls back up here and reach the
    // caller as a deasserted ready. A call is taken only once the last
    // answer has gone: this halves throughput but keeps every strobe
    // a single pulse with an idle cycle after it
    wire drain_ready = ~resp_valid;

    ssd_fifo #(
        .WIDTH (`SSD_CALL_W),
        .DEPTH (`SSD_FIFO_DEPTH),
        .AW    (`SSD_FIFO_AW)
    ) u_call_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .in_valid  (call_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({call_param, call_info}),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    // Registered copy of ready; the live term gates the push itself
    assign call_ready_q = call_ready_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_ready_r <= 1'b0;
        end else if (clk_en) begin
            call_ready_r <= fifo_in_ready;
        end
    end

    // ----------------------------------------------------------------
    // Call processing
    // ----------------------------------------------------------------
    wire       take     = clk_en & fifo_out_valid & drain_ready;
    wire [3:0] info     = fifo_out[`SSD_I3:`SSD_I0];
    wire       call_i0  = info[`SSD_I0];
    wire       call_i1  = info[`SSD_I1];
    wire       bank_sel = info[`SSD_I2];
    wire       ab_sel   = info[`SSD_I3];
    wire       is_param = (fifo_out[`SSD_CALL_KIND] == `SSD_KIND_PARAM);
    // Refused calls still leave the FIFO so a blocked slave never
    // holds up the calls queued behind them
    // I3 selects A/B
    wire       addr_ok  = ~ext_addr_mode | (ab_sel == b_slave);
    wire       exch_ok  = ~is_param & addr_ok & ~exchange_block;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exchange_block     <= 1'b1;
            prev_i2            <= 1'b0;
            pair_one_low_hold  <= 1'b0;
            pair_one_high_hold <= 1'b0;
            data_out           <= 4'h0;
            data_strobe        <= 1'b0;
            resp_valid         <= 1'b0;
            resp_data          <= 4'h0;
        end else if (clk_en) begin
            data_strobe <= 1'b0;
            if (resp_valid && resp_ready) begin
                resp_valid <= 1'b0;
            end
            if (safety_lock) begin
                exchange_block <= 1'b1;
            end
            if (take && is_param && !safety_lock) begin
                exchange_block <= 1'b0;
            end
            if (take && exch_ok) begin
                resp_valid <= 1'b1;
                resp_data  <= send_data;
                if (banked) begin
                    prev_i2 <= bank_sel;
                    if (bank_sel) begin
                        pair_one_low_hold  <= call_i0;
                        pair_one_high_hold <= call_i1;
                    end else if (prev_i2) begin
                        data_out    <= {call_i1, call_i0,
                                        pair_one_high_hold,
                                        pair_one_low_hold};
                        data_strobe <= 1'b1;
                    end
                end else if (ext_addr_mode) begin
                    // Only three output bits carry data with extended addressing but no banking
                    data_out[`SSD_I2:`SSD_I0] <= info[`SSD_I2:`SSD_I0];
                    data_strobe   <= 1'b1;
                end else begin
                    data_out    <= info;
                    data_strobe <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // No wait state: ready rises in the setup cycle's wake, read data
    // is latched with it so every bus output comes from a flip-flop
    wire setup  = psel & ~penable & ~pready;
    wire hit_c  = (paddr == `SSD_OFS_CONFIG);
    wire hit_s  = (paddr == `SSD_OFS_STATUS);
    wire hit_d  = (paddr == `SSD_OFS_DATA);
    wire mapped = hit_c | hit_s | hit_d;
    wire wr_acc = psel & penable & pready & pwrite & hit_c;

    reg [31:0] next_prdata;

    always @* begin
        next_prdata = 32'h0000_0000;
        if (hit_c) begin
            next_prdata[`SSD_CFG_W-1:0] = config_reg;
        end else if (hit_s) begin
            next_prdata[`SSD_ST_BLOCK]   = exchange_block;
            next_prdata[`SSD_ST_SAFETY]  = safety_on;
            next_prdata[`SSD_ST_PREV_I2] = prev_i2;
            next_prdata[`SSD_ST_LOCK]    = safety_lock;
            next_prdata[`SSD_ST_HOLD_LO] = pair_one_low_hold;
            next_prdata[`SSD_ST_HOLD_HI] = pair_one_high_hold;
            next_prdata[`SSD_ST_FIFO_HI:`SSD_ST_FIFO_LO] = fifo_level;
        end else if (hit_d) begin
            next_prdata[`SSD_DAT_IN_HI:`SSD_DAT_IN_LO]   = send_data;
            next_prdata[`SSD_DAT_OUT_HI:`SSD_DAT_OUT_LO] = data_out;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            config_reg <= `SSD_CFG_RESET;
        end else if (clk_en) begin
            if (setup) begin
                pready  <= 1'b1;
                pslverr <= ~mapped | (pwrite & ~hit_c);
                prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            end else begin
                // Read data falls back to zero so no stale word lingers
                pready  <= 1'b0;
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
            if (wr_acc) begin
                config_reg <= pwdata[`SSD_CFG_W-1:0];
            end
        end
    end

endmodule

// >>> test/ssd_code_gen.sv
// Model of the external safety code generator on the data inputs
module ssd_code_gen (
    // Control
    input  logic       safety,
    input  logic [3:0] code,
    // Data input pins
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stored;
    always_comb begin
        stored = (safety && code == 4'hE) ? 4'hF : code;
        pins = safety ? {stored[2], stored[3], stored[1:0]} : stored;
    end
endmodule

// >>> test/ssd_data_path_assertions.sv
// Port-level checker for the safe slave data path
module ssd_data_path_chk (
    // Clock, reset, enable
    input logic        pclk,
    input logic        presetn,
    input logic        clk_en,
    // APB slave
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Calls and answers
    input logic        call_valid,
    input logic        call_param,
    input logic        resp_valid,
    input logic        resp_ready,
    input logic [3:0]  resp_data,
    // Output pins
    input logic [3:0]  data_out,
    input logic        data_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_par;
    logic lock;
    // Lock mirrors the config write so no register read is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_par <= 1'h0;
            lock     <= 1'h0;
        end else begin
            if (clk_en && call_valid && call_param)
                seen_par <= 1'h1;
            if (clk_en && psel && penable && pready && pwrite
                && paddr == 12'h000)
                lock <= pwdata[0] && (pwdata[3] || |pwdata[13:10]);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_access;
        psel && penable && clk_en;
    endsequence
    a_apb_answer: assert property (s_setup ##1 s_access |-> pready)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_strobe_pulse: assert property (data_strobe |=> !data_strobe)
        else $error("strobe longer than one cycle");
    a_out_strobe: assert property ($changed(data_out) |-> data_strobe)
        else $error("outputs changed without strobe");
    a_strobe_answer: assert property (data_strobe |-> resp_valid)
        else $error("strobe without an answer");
    a_resp_hold: assert property (resp_valid && !resp_ready
        |=> resp_valid && $stable(resp_data))
        else $error("answer dropped before accepted");
    a_block_reset: assert property (resp_valid |-> seen_par)
        else $error("answer before any parameter call");
    a_lock_silent: assert property ($rose(resp_valid) |-> !lock)
        else $error("answer while configuration locked");
    a_freeze_state: assert property (!clk_en
        |=> $stable(data_out) && $stable(resp_valid) && $stable(pready))
        else $error("state moved while clock enable low");
endmodule

bind ssd_data_path ssd_data_path_chk i_ssd_data_path_chk (.*);

// >>> test/ssd_data_path_test.sv
// Self-checking bench for the safe slave data path
module ssd_data_path_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, call_valid, call_ready_q, call_param;
    logic [3:0]  call_info, resp_data, data_in_pin, data_out, code, last;
    logic        resp_valid, resp_ready, data_strobe, safety;
    logic [3:0]  tbl [4] = '{4'hE, 4'h8, 4'h3, 4'h0};
    int          n_mismatch, checks, n_ans, n_stb, n0, s0, k;

    ssd_data_path i_ssd_data_path (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .call_valid(call_valid),
        .call_ready_q(call_ready_q), .call_param(call_param),
        .call_info(call_info), .resp_valid(resp_valid),
        .resp_ready(resp_ready), .resp_data(resp_data),
        .data_in_pin(data_in_pin), .data_out(data_out),
        .data_strobe(data_strobe));
    ssd_code_gen i_ssd_code_gen (.safety(safety), .code(code),
        .pins(data_in_pin));

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (resp_valid && resp_ready) begin
            n_ans <= n_ans + 1;
            last  <= resp_data;
        end
        if (data_strobe)
            n_stb <= n_stb + 1;
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task call(input logic p, input logic [3:0] i);
        @(posedge pclk);
        call_valid <= 1'h1;
        call_param <= p;
        call_info  <= i;
        @(posedge pclk);
        call_valid <= 1'h0;
    endtask
    // Exchange call; settles pins first, then counts answers and strobes
    task xc(input logic [3:0] i, input int ans, stb, input logic [3:0] e);
        repeat (6) @(posedge pclk);
        n0 = n_ans;
        s0 = n_stb;
        call(1'h0, i);
        repeat (8) @(posedge pclk);
        chk("answers", n_ans - n0, ans);
        chk("strobes", n_stb - s0, stb);
        if (ans != 0)
            chk("resp_data", last, e);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, call_valid, call_param} = 6'h00;
        {clk_en, resp_ready, safety} = 3'h6;
        {paddr, pwdata, call_info, code} = {12'h000, 32'h0, 4'h0, 4'h5};
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h004, 32'h0);
        chk("status block", rd[0], 1'h1);
        chk("status holds", rd[5:4], 2'h0);
        apb(1'h0, 12'h0FC, 32'h0);
        chk("unmapped err", err, 1'h1);
        apb(1'h1, 12'h004, 32'h1);
        chk("read-only err", err, 1'h1);
        xc(4'h3, 0, 0, 4'h0);
        call(1'h1, 4'h0);
        xc(4'hA, 1, 1, 4'h5);
        chk("plain out", data_out, 4'hA);
        apb(1'h0, 12'h008, 32'h0);
        chk("data reg", rd[7:0], 8'hA5);
        $display("reset and block test done");
        apb(1'h1, 12'h000, 32'h6);
        apb(1'h0, 12'h000, 32'h0);
        chk("config reg", rd, 32'h6);
        xc(4'h6, 1, 0, 4'h5);
        apb(1'h0, 12'h004, 32'h0);
        chk("status holds", rd[5:4], 2'h2);
        xc(4'h1, 1, 1, 4'h5);
        chk("bank out", data_out, 4'h6);
        xc(4'h2, 1, 0, 4'h5);
        chk("bank out", data_out, 4'h6);
        xc(4'hC, 0, 0, 4'h0);
        apb(1'h1, 12'h000, 32'h26);
        xc(4'h8, 1, 0, 4'h5);
        apb(1'h1, 12'h000, 32'h4);
        xc(4'h6, 1, 1, 4'h5);
        chk("plain out", data_out, 4'h6);
        $display("banked output test done");
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h004, 32'h0);
        chk("reset block", rd[0], 1'h1);
        chk("reset holds", rd[5:4], 2'h0);
        call(1'h1, 4'h0);
        $display("mid-run reset test done");
        safety <= 1'h1;
        apb(1'h1, 12'h000, 32'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk("status safety", rd[1], 1'h1);
        for (k = 0; k < 4; k++) begin
            code <= tbl[k];
            xc(4'h0, 1, 1, tbl[k]);
        end
        apb(1'h1, 12'h000, 32'h201);
        code <= 4'h8;
        xc(4'h0, 1, 1, 4'hC);
        apb(1'h1, 12'h000, 32'h11);
        code <= 4'h0;
        xc(4'h0, 1, 1, 4'hE);
        apb(1'h1, 12'h000, 32'h401);
        call(1'h1, 4'h0);
        xc(4'h0, 0, 0, 4'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("status lock", rd[3:0], 4'hB);
        $display("safety mode test done");
        safety <= 1'h0;
        apb(1'h1, 12'h000, 32'h0);
        call(1'h1, 4'h0);
        resp_ready <= 1'h0;
        k = 0;
        n0 = n_ans;
        while (call_ready_q === 1'h1 && k < 12) begin
            call(1'h0, 4'h1);
            k++;
            repeat (2) @(posedge pclk);
        end
        apb(1'h0, 12'h004, 32'h0);
        chk("fifo level", rd[11:8], 4'h8);
        chk("fifo ready", call_ready_q, 1'h0);
        resp_ready <= 1'h1;
        repeat (40) @(posedge pclk);
        chk("drained answers", n_ans - n0, k);
        n0 = n_ans;
        call(1'h0, 4'h2);
        clk_en <= 1'h0;
        repeat (8) @(posedge pclk);
        chk("frozen answers", n_ans - n0, 0);
        clk_en <= 1'h1;
        repeat (8) @(posedge pclk);
        chk("resumed answers", n_ans - n0, 1);
        chk("resumed out", data_out, 4'h2);
        $display("buffer test done");
        results;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results;
    end
endmodule
